// ===== src/dsm_pkg.sv
// Operation
// - SPE is 87 columns by 9 rows
// - Each row holds 59 fixed stuff bits
// - Fixed stuff sent as zero, ignored on receive
// - Each row holds 621 dedicated data bits
// - Data positions carry payload and overhead alike
// - One stuff opportunity bit per row
// - Mapper picks opportunity use from timing difference
// - Five control bits flag the row's opportunity
// - All zero control means opportunity is data
// - All one control means opportunity is stuff
// - Two overhead communication bits per row
// - Nominal rate gives 5592 bits per envelope
package dsm_pkg;

	// ****************************************************************
	// Envelope geometry.
	// ****************************************************************
	localparam int SPE_COLS  = 87;
	localparam int SPE_ROWS  = 9;
	localparam int ROW_BITS  = SPE_COLS * 8;
	localparam int POH_BITS  = 8;
	localparam int CTRL_BITS = 5;
	localparam int OH_BITS   = 2;
	localparam int FIX_BITS  = 59;
	localparam int DATA_BITS = 621;

	// Bit positions inside one row; control precedes the opportunity
	// bit so the receiver has voted before the opportunity arrives.
	localparam logic [9:0] CTRL_FIRST = 10'h008;
	localparam logic [9:0] OH_FIRST   = 10'h00d;
	localparam logic [9:0] FIX_FIRST  = 10'h00f;
	localparam logic [9:0] OPP_POS    = 10'h04a;
	localparam logic [9:0] DATA_FIRST = 10'h04b;
	localparam logic [9:0] ROW_LAST   = 10'h2b7;
	localparam logic [3:0] ROW_FINAL  = 4'h8;
	localparam logic [2:0] VOTE_MIN   = 3'h3;

	// FIFO fill at or above which the opportunity bit carries data.
	localparam logic [2:0] JUST_LEVEL = 3'h2;
	localparam int         FIFO_W     = 1;
	localparam int         FIFO_D     = 4;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef enum logic [2:0] {
		K_POH  = 3'b000,
		K_CTRL = 3'b001,
		K_OH   = 3'b010,
		K_FIX  = 3'b011,
		K_OPP  = 3'b100,
		K_DATA = 3'b101
	} dsm_kind_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} dsm_state_t;

	// Classifies a bit position within a row.
	function automatic dsm_kind_t kind_of(input logic [9:0] pos);
		dsm_kind_t k;
		if (pos < CTRL_FIRST) begin
			k = K_POH;
		end else if (pos < OH_FIRST) begin
			k = K_CTRL;
		end else if (pos < FIX_FIRST) begin
			k = K_OH;
		end else if (pos < OPP_POS) begin
			k = K_FIX;
		end else if (pos == OPP_POS) begin
			k = K_OPP;
		end else begin
			k = K_DATA;
		end
		return k;
	endfunction : kind_of

endpackage : dsm_pkg

// ===== src/dsm_link_if.sv
// Serial envelope link between mapper and de-mapper, one bit a cycle.
interface dsm_link_if;
	logic spe_bit;
	logic spe_valid;
	logic spe_sof;

	modport mapper (output spe_bit, output spe_valid, output spe_sof);
	modport demapper (input spe_bit, input spe_valid, input spe_sof);
endinterface : dsm_link_if

// ===== src/dsm_mapper.sv
// ****************************************************************
// Small FIFO between the tributary source and the envelope builder.
// ****************************************************************
module dsm_fifo #(
	parameter int W = 1,
	parameter int D = 4
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     ce,
	input  wire logic [W-1:0]             in_data,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	output logic [W-1:0]                  out_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [$clog2(D+1)-1:0]        level
);
	localparam int CW = $clog2(D+1);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam logic [CW-1:0] FULL = CW'(D);

	logic [W-1:0]  mem_reg [D];
	logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic          rdy_reg, rdy_next;
	logic          push, pop;

	// Pointers and count; ready is registered so the source sees a flop.
	always_comb begin
		push     = in_valid && rdy_reg;
		pop      = out_ready && (cnt_reg != '0);
		wp_next  = wp_reg;
		rp_next  = rp_reg;
		if (push) begin
			wp_next = (wp_reg == PW'(D-1)) ? '0 : wp_reg + 1'b1;
		end
		if (pop) begin
			rp_next = (rp_reg == PW'(D-1)) ? '0 : rp_reg + 1'b1;
		end
		cnt_next = cnt_reg + CW'(push) - CW'(pop);
		rdy_next = (cnt_next != FULL);
	end

	// Register pointers, count and ready; a low enable holds them all.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b1;
		end else if (ce) begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
		end
	end

	// Storage has no reset; empty slots are never read.
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_reg[wp_reg] <= in_data;
		end
	end

	// Ready and level come straight from registers; data is read in place.
	assign in_ready  = rdy_reg;
	assign out_data  = mem_reg[rp_reg];
	assign out_valid = (cnt_reg != '0);
	assign level     = cnt_reg;
endmodule : dsm_fifo

// ****************************************************************
// Envelope builder: tributary bits in, envelope bits out.
// ****************************************************************
module dsm_mapper (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        map_en,
	input  wire logic        ds3_bit,
	input  wire logic        ds3_valid,
	output logic             ds3_ready,
	input  wire logic [1:0]  oh_bits,
	output logic             underrun,
	dsm_link_if.mapper       lnk
);
	dsm_pkg::dsm_state_t st_reg, st_next;
	dsm_pkg::dsm_kind_t  kind;
	logic [9:0] pos_reg, pos_next;
	logic [3:0] row_reg, row_next;
	logic       stuff_reg, stuff_next;
	logic       bit_reg, bit_next;
	logic       val_reg, val_next;
	logic       sof_reg, sof_next;
	logic       unr_reg, unr_next;
	logic       dec;
	logic       pop;
	logic       f_data, f_valid;
	logic [2:0] f_level;
	logic       run;
	logic       last;

	// The FIFO absorbs the phase wander between the tributary and the
	// envelope clock, and its fill level drives the justification choice.
	// Four words leave headroom above the threshold, so a source at full
	// rate keeps the level high enough to fill the opportunity bits.
	dsm_fifo #(.W(dsm_pkg::FIFO_W), .D(dsm_pkg::FIFO_D)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.in_data   (ds3_bit),
		.in_valid  (ds3_valid),
		.in_ready  (ds3_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (pop),
		.level     (f_level)
	);

	// Walk the envelope bit by bit and pick each bit's content.
	always_comb begin
		st_next    = st_reg;
		pos_next   = pos_reg;
		row_next   = row_reg;
		stuff_next = stuff_reg;
		bit_next   = 1'b0;
		sof_next   = 1'b0;
		unr_next   = 1'b0;
		pop        = 1'b0;
		run        = (st_reg == dsm_pkg::ST_RUN);
		last       = (pos_reg == dsm_pkg::ROW_LAST);
		kind       = dsm_pkg::kind_of(pos_reg);
		// A low fill means the tributary runs slow against our clock,
		// so the opportunity is stuffed; a nominal source lands near
		// three data opportunities per envelope.
		dec = (pos_reg == dsm_pkg::CTRL_FIRST) ?
			(f_level < dsm_pkg::JUST_LEVEL) : stuff_reg;
		val_next = run;
		if (run) begin
			sof_next = (pos_reg == '0) && (row_reg == '0);
			case (kind)
				dsm_pkg::K_CTRL: begin
					stuff_next = dec;
					bit_next   = dec;
				end
				dsm_pkg::K_OH: begin
					bit_next = oh_bits[pos_reg[0] ? 1 : 0];
				end
				dsm_pkg::K_OPP: begin
					pop      = !stuff_reg;
					bit_next = !stuff_reg && f_data && f_valid;
					unr_next = !stuff_reg && !f_valid;
				end
				dsm_pkg::K_DATA: begin
					// Payload and framing bits are treated alike.
					pop      = 1'b1;
					bit_next = f_data && f_valid;
					unr_next = !f_valid;
				end
				default: begin
					bit_next = 1'b0;
				end
			endcase
			pos_next = last ? '0 : pos_reg + 10'h001;
			if (last) begin
				row_next = (row_reg == dsm_pkg::ROW_FINAL) ?
					'0 : row_reg + 4'h1;
			end
			// Stop only on an envelope boundary.
			if (!map_en && last && row_reg == dsm_pkg::ROW_FINAL) begin
				st_next = dsm_pkg::ST_IDLE;
			end
		end else if (map_en) begin
			st_next  = dsm_pkg::ST_RUN;
			pos_next = '0;
			row_next = '0;
		end
	end

	// Register the walk; a low clock enable freezes the whole envelope.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg    <= dsm_pkg::ST_IDLE;
			pos_reg   <= '0;
			row_reg   <= '0;
			stuff_reg <= 1'b1;
			bit_reg   <= 1'b0;
			val_reg   <= 1'b0;
			sof_reg   <= 1'b0;
			unr_reg   <= 1'b0;
		end else if (ce) begin
			st_reg    <= st_next;
			pos_reg   <= pos_next;
			row_reg   <= row_next;
			stuff_reg <= stuff_next;
			bit_reg   <= bit_next;
			val_reg   <= val_next;
			sof_reg   <= sof_next;
			unr_reg   <= unr_next;
		end
	end

	// Link and status outputs are driven straight from the registers.
	assign lnk.spe_bit   = bit_reg;
	assign lnk.spe_valid = val_reg;
	assign lnk.spe_sof   = sof_reg;
	assign underrun      = unr_reg;
endmodule : dsm_mapper

// ===== src/dsm_demapper.sv
// ****************************************************************
// Envelope reader: envelope bits in, tributary bits out.
// ****************************************************************
module dsm_demapper (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	dsm_link_if.demapper     lnk,
	output logic             ds3_bit,
	output logic             ds3_valid,
	output logic [1:0]       oh_bits,
	output logic             oh_valid,
	output logic             locked
);
	dsm_pkg::dsm_state_t st_reg, st_next;
	dsm_pkg::dsm_kind_t  kind;
	logic [9:0] pos_reg, pos_next, cur_pos;
	logic [3:0] row_reg, row_next, cur_row;
	logic [2:0] ones_reg, ones_next;
	logic       bit_reg, bit_next;
	logic       val_reg, val_next;
	logic [1:0] oh_reg, oh_next;
	logic       ohv_reg, ohv_next;
	logic       act;

	// Track position from the start marker and sort each bit.
	always_comb begin
		st_next   = st_reg;
		pos_next  = pos_reg;
		row_next  = row_reg;
		ones_next = ones_reg;
		oh_next   = oh_reg;
		bit_next  = 1'b0;
		val_next  = 1'b0;
		ohv_next  = 1'b0;
		cur_pos   = lnk.spe_sof ? '0 : pos_reg;
		cur_row   = lnk.spe_sof ? '0 : row_reg;
		act       = lnk.spe_valid &&
			(lnk.spe_sof || st_reg == dsm_pkg::ST_RUN);
		kind      = dsm_pkg::kind_of(cur_pos);
		if (act) begin
			st_next = dsm_pkg::ST_RUN;
			case (kind)
				dsm_pkg::K_CTRL: begin
					// Majority survives up to two corrupted flags.
					ones_next = ((cur_pos == dsm_pkg::CTRL_FIRST) ?
						3'h0 : ones_reg) + 3'(lnk.spe_bit);
				end
				dsm_pkg::K_OH: begin
					oh_next[cur_pos[0] ? 1 : 0] = lnk.spe_bit;
					ohv_next = (cur_pos == dsm_pkg::FIX_FIRST - 10'h001);
				end
				dsm_pkg::K_OPP: begin
					bit_next = lnk.spe_bit;
					val_next = (ones_reg < dsm_pkg::VOTE_MIN);
				end
				dsm_pkg::K_DATA: begin
					bit_next = lnk.spe_bit;
					val_next = 1'b1;
				end
				default: begin
					val_next = 1'b0;
				end
			endcase
			if (cur_pos == dsm_pkg::ROW_LAST) begin
				pos_next = '0;
				row_next = (cur_row == dsm_pkg::ROW_FINAL) ?
					'0 : cur_row + 4'h1;
			end else begin
				pos_next = cur_pos + 10'h001;
				row_next = cur_row;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg   <= dsm_pkg::ST_IDLE;
			pos_reg  <= '0;
			row_reg  <= '0;
			ones_reg <= '0;
			bit_reg  <= 1'b0;
			val_reg  <= 1'b0;
			oh_reg   <= 2'h0;
			ohv_reg  <= 1'b0;
		end else if (ce) begin
			st_reg   <= st_next;
			pos_reg  <= pos_next;
			row_reg  <= row_next;
			ones_reg <= ones_next;
			bit_reg  <= bit_next;
			val_reg  <= val_next;
			oh_reg   <= oh_next;
			ohv_reg  <= ohv_next;
		end
	end

	assign ds3_bit   = bit_reg;
	assign ds3_valid = val_reg;
	assign oh_bits   = oh_reg;
	assign oh_valid  = ohv_reg;
	assign locked    = (st_reg == dsm_pkg::ST_RUN);
endmodule : dsm_demapper

// ===== verification/dsm_link_asserts.sv
// ****************************************************************
// Link checker: watches the envelope stream between the two ends.
// ****************************************************************
module dsm_link_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spe_bit,
	input wire logic spe_valid,
	input wire logic spe_sof
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] pos_reg, pos_next;
	logic [3:0] row_reg, row_next;
	logic       on_reg, on_next;
	logic       last, chk;

	// Position of the next bit; a start of frame realigns it.
	always_comb begin
		last = pos_reg == 10'h2b7;
		pos_next = pos_reg;
		row_next = row_reg;
		on_next = on_reg | spe_sof;
		if (spe_valid && spe_sof) begin
			pos_next = 10'h001;
			row_next = 4'h0;
		end else if (spe_valid) begin
			pos_next = last ? 10'h000 : pos_reg + 10'h001;
			if (last) begin
				row_next = (row_reg == 4'h8) ? 4'h0 : row_reg + 4'h1;
			end
		end
	end

	// Plain registers; cleared by reset so a restart relearns the frame.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_reg <= 10'h000;
			row_reg <= 4'h0;
			on_reg <= 1'b0;
		end else begin
			pos_reg <= pos_next;
			row_reg <= row_next;
			on_reg <= on_next;
		end
	end

	assign chk = spe_valid && on_reg && !spe_sof;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_SOF_VALID: assert property (spe_sof |-> spe_valid)
		else $error("sof without valid");
	AST_SOF_PLACE: assert property (spe_sof && on_reg |->
		pos_reg == 10'h000 && row_reg == 4'h0) else $error("sof misplaced");
	AST_SOF_SINGLE: assert property (spe_sof |=> !spe_sof [*8])
		else $error("sof repeated");
	AST_POH_ZERO: assert property (chk && pos_reg < 10'h008 |->
		!spe_bit) else $error("overhead bit not zero");
	AST_FIX_ZERO: assert property (chk && pos_reg >= 10'h00f &&
		pos_reg < 10'h04a |-> !spe_bit) else $error("fixed stuff set");
	AST_CTRL_SAME: assert property (chk && pos_reg > 10'h008 &&
		pos_reg < 10'h00d |-> spe_bit == $past(spe_bit))
		else $error("control bits differ");
	AST_RUN_ON: assert property (spe_valid &&
		!(last && row_reg == 4'h8) |=> spe_valid) else $error("gap in row");
	AST_ENV_STOP: assert property (spe_valid && last &&
		row_reg == 4'h8 |=> !spe_valid || spe_sof) else $error("no sof");

	AST_COV_SOF: cover property (spe_sof);
	AST_COV_OPP_DATA: cover property (chk && pos_reg == 10'h00c && !spe_bit);
	AST_COV_OPP_STUFF: cover property (chk && pos_reg == 10'h00c && spe_bit);
endmodule : dsm_link_asserts

// ===== verification/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, map_en, src_bit, src_valid, src_ready;
	logic        underrun, out_bit, out_valid, oh_valid, locked;
	logic        d1_v, d1_b, d2_v, d2_b, oh_pend, e;
	logic [1:0]  oh_in, oh_out;
	logic [31:0] rng;
	int          mismatches, checks_done, i, unr_count;
	logic        q_bits[$];
	logic [1:0]  q_oh[$];

	dsm_link_if lnk ();
	dsm_mapper dsm_mapper_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.map_en(map_en), .ds3_bit(src_bit), .ds3_valid(src_valid),
		.ds3_ready(src_ready), .oh_bits(oh_in), .underrun(underrun),
		.lnk(lnk.mapper));
	dsm_demapper dsm_demapper_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.lnk(lnk.demapper), .ds3_bit(out_bit), .ds3_valid(out_valid),
		.oh_bits(oh_out), .oh_valid(oh_valid), .locked(locked));
	dsm_link_asserts dsm_link_asserts_i (.clk(clk), .rst_n(rst_n),
		.spe_bit(lnk.spe_bit), .spe_valid(lnk.spe_valid),
		.spe_sof(lnk.spe_sof));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic check(input logic [1:0] seen, input logic [1:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %b expected %b", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	// Drives the source; dens sixteenths of the cycles offer a bit.
	task automatic run(input int n, input int dens);
		repeat (n) begin
			@(posedge clk);
			#2;
			rng = xs(rng);
			src_bit = rng[0];
			src_valid = int'(rng[7:4]) < dens;
			if (oh_pend) begin
				oh_pend = 1'b0;
				oh_in = rng[9:8];
				q_oh.push_back(rng[9:8]);
			end
		end
	endtask : run

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Accepted bits are queued two samples late, so that the zero of an
	// underrun goes ahead of a bit taken on the edge that found no data.
	always @(negedge clk) begin
		if (rst_n) begin
			if (underrun === 1'b1) begin
				q_bits.push_back(1'b0);
				unr_count++;
			end
			if (d2_v) q_bits.push_back(d2_b);
			d2_v = d1_v;
			d2_b = d1_b;
			d1_v = src_valid && src_ready === 1'b1;
			d1_b = src_bit;
			if (out_valid === 1'b1) begin
				e = q_bits.size() > 0 ? q_bits.pop_front() : 1'bx;
				check({1'b0, out_bit}, {1'b0, e});
			end
			if (oh_valid === 1'b1) begin
				check(oh_out, q_oh.size() > 0 ? q_oh.pop_front() : 2'bxx);
				oh_pend = 1'b1;
			end
		end
	end

	// Full rate first (data opportunities), then half rate (stuffing).
	initial begin
		rst_n = 1'b0;
		map_en = 1'b0;
		src_bit = 1'b0;
		src_valid = 1'b0;
		oh_in = 2'h1;
		rng = 32'h913ba2e0;
		{d1_v, d1_b, d2_v, d2_b, oh_pend} = 5'h00;
		q_oh.push_back(2'h1);
		repeat (16) @(posedge clk);
		#2 rst_n = 1'b1;
		check({1'b0, src_ready}, 2'b01);
		map_en = 1'b1;
		run(20000, 16);
		check({1'b0, unr_count != 0}, 2'b00);
		run(20000, 8);
		check({1'b0, unr_count != 0}, 2'b01);
		map_en = 1'b0;
		// The source goes quiet but overhead bits are still served, since
		// rows of the last envelope keep sampling them until it ends.
		for (i = 0; i < 7000 && lnk.spe_valid !== 1'b0; i++) begin
			run(1, 0);
		end
		check({1'b0, lnk.spe_valid}, 2'b00);
		check({1'b0, locked}, 2'b01);
		map_en = 1'b1;
		run(8000, 14);
		final_report();
	end
endmodule : tb
